// ---- rtl/lss_scan.sv ----
// Top of the LCD scan block: slot sequencer, polarity, and drive encoders.
// Assumes clk is the LCD slot clock and CPU inputs come from the same domain.
// Common and segment drive outputs are 2-bit rail codes for an external analog switch matrix.
`default_nettype none

module lss_scan
  import lss_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_we,
  input wire logic cpu_re,
  output logic [7:0] cpu_rdata,
  input wire logic display_on,
  input wire logic four_slot,
  input wire logic static_mode,
  input wire logic lcd_boost_ctrl,
  output logic ref_drive_level,
  output logic [1:0] common_drive_0,
  output logic [1:0] common_drive_1,
  output logic [1:0] common_drive_2,
  output logic [1:0] common_drive_3,
  output logic [23:0][1:0] segment_out
);

  logic [1:0] slot_q;
  logic [1:0] slot_d;
  logic pol_q;
  logic pol_d;
  logic [1:0] slot_p_q;
  logic [1:0] slot_p_d;
  logic pol_p_q;
  logic pol_p_d;
  logic [1:0] last_slot;
  logic [23:0] col;
  logic [3:0][1:0] com_q;
  logic [3:0][1:0] com_d;
  logic [23:0][1:0] seg_q;
  logic [23:0][1:0] seg_d;
  logic ref_q;
  logic ref_d;

  lss_mem u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(cpu_we),
    .rd_en(cpu_re),
    .addr(cpu_addr),
    .wdata(cpu_wdata[3:0]),
    .rdata(cpu_rdata),
    .col_sel(slot_q),
    .col(col)
  );

  // ****************************************************************
  // Slot sequencer and frame polarity
  // ****************************************************************
  always_comb begin
    if (static_mode) begin
      last_slot = LSS_SLOT_LAST_STATIC;
    end else if (four_slot) begin
      last_slot = LSS_SLOT_LAST_FOUR; // see RULE_07
    end else begin
      last_slot = LSS_SLOT_LAST_THREE; // see RULE_07 see RULE_04
    end
    if (slot_q >= last_slot) begin
      slot_d = LSS_SLOT_FIRST; // see RULE_12
      pol_d = ~pol_q; // see RULE_09 see RULE_12
    end else begin
      slot_d = slot_q + 2'h1; // see RULE_12
      pol_d = pol_q;
    end
    slot_p_d = slot_q;
    pol_p_d = pol_q;
    ref_d = lcd_boost_ctrl; // see RULE_10
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slot_q <= LSS_SLOT_FIRST;
      pol_q <= 1'b0;
      slot_p_q <= LSS_SLOT_FIRST;
      pol_p_q <= 1'b0;
      ref_q <= LSS_REF_HIGH_SET;
    end else begin
      slot_q <= slot_d;
      pol_q <= pol_d;
      slot_p_q <= slot_p_d;
      pol_p_q <= pol_p_d;
      ref_q <= ref_d;
    end
  end

  // ****************************************************************
  // Drive encoders
  // ****************************************************************
  // Selected common and selected segment sit on opposite outer rails;
  // every other pairing with a scanned common differs by one third of the drive voltage.
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      if (!display_on) begin
        com_d[c] = LSS_LVL_VSS;
      end else if (static_mode || slot_p_q == c[1:0]) begin
        com_d[c] = pol_p_q ? LSS_LVL_VSS : LSS_LVL_TOP; // see RULE_11 see RULE_09
      end else begin
        com_d[c] = pol_p_q ? LSS_LVL_TWO_THIRDS : LSS_LVL_ONE_THIRD;
      end
    end
    if (display_on && !static_mode && !four_slot) begin
      com_d[3] = LSS_LVL_VSS; // see RULE_11
    end
    for (int s = 0; s < LSS_SEG_COUNT; s++) begin
      if (!display_on) begin
        seg_d[s] = LSS_LVL_VSS;
      end else if (col[s]) begin
        seg_d[s] = pol_p_q ? LSS_LVL_TOP : LSS_LVL_VSS; // see RULE_03 see RULE_06
      end else begin
        seg_d[s] = pol_p_q ? LSS_LVL_ONE_THIRD : LSS_LVL_TWO_THIRDS; // see RULE_03 see RULE_06
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      com_q <= '0;
      seg_q <= '0;
    end else begin
      com_q <= com_d;
      seg_q <= seg_d;
    end
  end

  assign common_drive_0 = com_q[0];
  assign common_drive_1 = com_q[1];
  assign common_drive_2 = com_q[2];
  assign common_drive_3 = com_q[3];
  assign segment_out = seg_q;
  assign ref_drive_level = ref_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_slot_wrap;
    @(posedge clk) disable iff (sys_rst)
      (slot_q == LSS_SLOT_LAST_FOUR) |=> (slot_q == LSS_SLOT_FIRST);
  endproperty
  a_slot_wrap: assert property (p_slot_wrap) else $error("slot did not wrap"); // see RULE_12

  property p_three_slot;
    @(posedge clk) disable iff (sys_rst)
      (!four_slot && !static_mode) [*2] |-> (slot_q <= LSS_SLOT_LAST_THREE);
  endproperty
  a_three_slot: assert property (p_three_slot) else $error("slot 3 in three-slot"); // see RULE_07

  property p_pixel_on;
    @(posedge clk) disable iff (sys_rst)
      (display_on && !static_mode && slot_p_q == 2'h0 && col[0])
        |=> ((common_drive_0 == LSS_LVL_TOP && segment_out[0] == LSS_LVL_VSS) ||
          (common_drive_0 == LSS_LVL_VSS && segment_out[0] == LSS_LVL_TOP));
  endproperty
  a_pixel_on: assert property (p_pixel_on) else $error("on pixel not full drive"); // see RULE_06

  property p_pixel_off;
    @(posedge clk) disable iff (sys_rst)
      (display_on && !col[0]) |=> (segment_out[0] == LSS_LVL_TWO_THIRDS ||
        segment_out[0] == LSS_LVL_ONE_THIRD);
  endproperty
  a_pixel_off: assert property (p_pixel_off) else $error("deselect level wrong"); // see RULE_03

  property p_upper_zero;
    @(posedge clk) disable iff (sys_rst)
      cpu_re |=> (cpu_rdata[7:4] == 4'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero"); // see RULE_05

  property p_write_read;
    @(posedge clk) disable iff (sys_rst)
      (cpu_we && cpu_addr <= LSS_LAST_ADDR) ##1
        (cpu_re && !cpu_we && cpu_addr == $past(cpu_addr))
        |=> (cpu_rdata[3:0] == $past(cpu_wdata[3:0], 2));
  endproperty
  a_write_read: assert property (p_write_read) else $error("stored data lost"); // see RULE_08

  property p_pol_flip;
    @(posedge clk) disable iff (sys_rst)
      (slot_q == LSS_SLOT_FIRST) ##1 (slot_q == LSS_SLOT_FIRST) |-> (pol_q != $past(pol_q));
  endproperty
  a_pol_flip: assert property (p_pol_flip) else $error("polarity did not flip"); // see RULE_09

  property p_ref_level;
    @(posedge clk) disable iff (sys_rst)
      1'b1 |=> (ref_drive_level == $past(lcd_boost_ctrl));
  endproperty
  a_ref_level: assert property (p_ref_level) else $error("reference level wrong"); // see RULE_10

  property p_static_same;
    @(posedge clk) disable iff (sys_rst)
      static_mode |=> (common_drive_0 == common_drive_3 && common_drive_1 == common_drive_2 &&
        common_drive_0 == common_drive_1);
  endproperty
  a_static_same: assert property (p_static_same) else $error("static commons differ"); // see RULE_11

endmodule : lss_scan

`default_nettype wire

// ---- rtl/lss_pkg.sv ----
// Constants for the LCD segment and common scan block.
// Assumes one 25 MHz clock that is also the LCD slot clock, and a
// synchronous active-high reset.
//
// Summary of operation
// RULE_01: One memory byte per segment, ascending addresses.
// RULE_02: Slot n samples bit n of each byte.
// RULE_03: Bit one selects segment, zero deselects it.
// RULE_04: Three-slot mode leaves bit 3 as storage.
// RULE_05: Upper four bits absent, always read zero.
// RULE_06: Pixel on only when common and segment selected.
// RULE_07: Three slots scan three commons, four scan four.
// RULE_08: Undisplayed memory bits are ordinary read/write storage.
// RULE_09: Alternate drive polarity so pixels see no DC.
// RULE_10: Boost bit zero gives 1.5 V, one 1.0 V.
// RULE_11: Static drives all commons alike; three-slot idles fourth.
// RULE_12: One clock per slot, ascending, polarity flips per frame.
`default_nettype none

package lss_pkg;

  // ****************************************************************
  // Memory geometry
  // ****************************************************************
  localparam int unsigned LSS_SEG_COUNT = 24;
  localparam int unsigned LSS_ADDR_W = 5;
  localparam logic [4:0] LSS_LAST_ADDR = 5'h17;
  localparam int unsigned LSS_DATA_BITS = 4;
  localparam logic [3:0] LSS_MEM_RESET = 4'h0;
  localparam logic [7:0] LSS_RDATA_RESET = 8'h00;

  // ****************************************************************
  // Slot sequencing
  // ****************************************************************
  localparam logic [1:0] LSS_SLOT_FIRST = 2'h0;
  localparam logic [1:0] LSS_SLOT_LAST_STATIC = 2'h0;
  localparam logic [1:0] LSS_SLOT_LAST_THREE = 2'h2;
  localparam logic [1:0] LSS_SLOT_LAST_FOUR = 2'h3;

  // ****************************************************************
  // Drive level codes, highest rail first
  // ****************************************************************
  localparam logic [1:0] LSS_LVL_TOP = 2'h3;
  localparam logic [1:0] LSS_LVL_TWO_THIRDS = 2'h2;
  localparam logic [1:0] LSS_LVL_ONE_THIRD = 2'h1;
  localparam logic [1:0] LSS_LVL_VSS = 2'h0;

  // Reference level select: zero is the 1.5 V set, one the 1.0 V set.
  localparam logic LSS_REF_HIGH_SET = 1'b0;

endpackage : lss_pkg

`default_nettype wire

// ---- rtl/lss_mem.sv ----
// Display data memory: 24 words of four bits.
// Assumes a single clock; the CPU port and the scan port are both registered.
`default_nettype none

module lss_mem
  import lss_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [4:0] addr,
  input wire logic [3:0] wdata,
  output logic [7:0] rdata,
  input wire logic [1:0] col_sel,
  output logic [23:0] col
);

  logic [3:0] mem_q [LSS_SEG_COUNT];
  logic [3:0] mem_d [LSS_SEG_COUNT];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [23:0] col_q;
  logic [23:0] col_d;

  // ****************************************************************
  // Storage and read paths
  // ****************************************************************
  always_comb begin
    mem_d = mem_q;
    rdata_d = rdata_q;
    if (wr_en && addr <= LSS_LAST_ADDR) begin
      mem_d[addr] = wdata; // see RULE_08
    end
    if (rd_en) begin
      if (addr <= LSS_LAST_ADDR) begin
        rdata_d = {4'h0, mem_q[addr]}; // see RULE_05
      end else begin
        rdata_d = LSS_RDATA_RESET;
      end
    end
    for (int i = 0; i < LSS_SEG_COUNT; i++) begin
      col_d[i] = mem_q[i][col_sel]; // see RULE_01 see RULE_02
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < LSS_SEG_COUNT; i++) begin
        mem_q[i] <= LSS_MEM_RESET;
      end
      rdata_q <= LSS_RDATA_RESET;
      col_q <= '0;
    end else begin
      mem_q <= mem_d;
      rdata_q <= rdata_d;
      col_q <= col_d;
    end
  end

  assign rdata = rdata_q;
  assign col = col_q;

endmodule : lss_mem

`default_nettype wire

// ---- test/lss_panel.sv ----
// Panel model: marks the pixels that see the full drive in each slot.
// Assumes 2-bit rail codes where 3 is the top rail and 0 is ground.
`default_nettype none

module lss_panel (
  input wire logic [3:0][1:0] com,
  input wire logic [23:0][1:0] seg,
  output logic [3:0][23:0] lit
);
  timeunit 1ns;
  timeprecision 1ps;

  // Only the two outer rails facing each other give the full drive, with either sign.
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      for (int i = 0; i < 24; i++) begin
        lit[n][i] = (com[n] == 2'h3 && seg[i] == 2'h0) ||
          (com[n] == 2'h0 && seg[i] == 2'h3);
      end
    end
  end
endmodule : lss_panel

`default_nettype wire

// ---- test/testbench.sv ----
// Testbench: loads the display memory, then checks every scan slot per mode.
// Assumes one clock; inputs change at the falling edge.
`default_nettype none

module testbench
  import lss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, cpu_we, cpu_re, display_on, four_slot, static_mode, boost, ref_lvl;
  logic [4:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata;
  wire [3:0][1:0] com;
  logic [23:0][1:0] seg;
  logic [3:0][23:0] lit;
  logic [3:0] mem [24];
  int bad_count = 0;
  int num_checks = 0;
  int s, p, frame;

  lss_scan lss_scan_inst (.clk(clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_we(cpu_we), .cpu_re(cpu_re), .cpu_rdata(cpu_rdata),
    .display_on(display_on), .four_slot(four_slot), .static_mode(static_mode),
    .lcd_boost_ctrl(boost), .ref_drive_level(ref_lvl), .common_drive_0(com[0]),
    .common_drive_1(com[1]), .common_drive_2(com[2]), .common_drive_3(com[3]),
    .segment_out(seg));
  lss_panel lss_panel_inst (.com(com), .seg(seg), .lit(lit));

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Strobes stay up across back-to-back calls; the caller drops them at the end.
  task automatic wr(logic [4:0] a, logic [7:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_re = 1'b0;
    cpu_we = 1'b1;
    @(negedge clk);
  endtask : wr

  task automatic rd(logic [4:0] a, logic [7:0] exp);
    cpu_addr = a;
    cpu_we = 1'b0;
    cpu_re = 1'b1;
    @(negedge clk);
    check("rdata", cpu_rdata, exp);
  endtask : rd

  // Resets, then fills memory with random words (word 0 all ones) and junk in the upper half.
  task automatic start(logic f, logic st);
    sys_rst = 1'b1;
    four_slot = f;
    static_mode = st;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < LSS_SEG_COUNT; i++) begin
      mem[i] = (i == 0) ? 4'hF : 4'($urandom);
      wr(5'(i), {4'($urandom), mem[i]});
    end
    wr(5'h18, 8'hFF);
    for (int i = 0; i < LSS_SEG_COUNT; i++) rd(5'(i), {4'h0, mem[i]});
    mem[5] = 4'($urandom);
    wr(5'h05, {4'hA, mem[5]});
    rd(5'h05, {4'h0, mem[5]});
    rd(5'h1F, 8'h00);
    cpu_re = 1'b0;
    repeat (3) @(negedge clk);
  endtask : start

  task automatic scan(int cycles);
    logic [3:0][1:0] ec;
    logic [23:0][1:0] es;
    logic b;
    frame = static_mode ? 1 : (four_slot ? 4 : 3);
    s = -1;
    for (int k = 0; k < cycles; k++) begin
      boost = 1'($urandom);
      @(negedge clk);
      check("ref", ref_lvl, boost);
      if (s < 0) begin
        for (int n = 0; n < frame; n++) begin
          if (com[n] == 2'h3 || com[n] == 2'h0) begin
            s = n;
            p = (com[n] == 2'h0);
          end
        end
      end else begin
        if (s == frame - 1) p = 1 - p;
        s = (s + 1) % frame;
      end
      for (int n = 0; n < 4; n++) begin
        if (static_mode || n == s) ec[n] = p ? 2'h0 : 2'h3;
        else if (n >= frame) ec[n] = 2'h0;
        else ec[n] = p ? 2'h2 : 2'h1;
      end
      for (int i = 0; i < 24; i++) begin
        b = mem[i][s];
        es[i] = b ? (p ? 2'h3 : 2'h0) : (p ? 2'h1 : 2'h2);
      end
      check("common", com, ec);
      check("segment", seg, es);
      for (int n = 0; n < (static_mode ? 4 : frame); n++) begin
        for (int i = 0; i < 24; i++) es[i] = {1'b0, mem[i][s] && (static_mode || n == s)};
        for (int i = 0; i < 24; i++) check("pixel", lit[n][i], es[i]);
      end
    end
  endtask : scan

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    cpu_we = 1'b0;
    cpu_re = 1'b0;
    cpu_addr = 5'h00;
    cpu_wdata = 8'h00;
    display_on = 1'b1;
    boost = 1'b0;
    void'($urandom(32'h2C8B));
    start(1'b1, 1'b0);
    scan(40);
    start(1'b0, 1'b0);
    scan(40);
    start(1'b1, 1'b1);
    scan(20);
    display_on = 1'b0;
    repeat (3) @(negedge clk);
    check("off", {com, seg}, 64'h0);
    summarize();
  end

  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule : testbench

`default_nettype wire
